// ---- core/rwsc_top.v ----
// Overview of operation
// - reset input low clears all internal logic and registers.
// - undriven reset input falls back to internal power-on reset.
// - when enabled, a detected wake event asserts the wake request.
// - software selects wake request polarity and push-pull or open-drain.
// - wake request does not wake device; only chip select plus write does.
// - while asleep any qualified write wakes, whatever its data.
// - speed strap level is captured when reset is released.
// - strap 0 gives 10M half no autoneg; 1 gives 100M half autoneg.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "rwsc_consts.vh"
module rwsc_top (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // power-on reset from the analog cell, active low
  input  wire        por_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // host pins, asynchronous
  input  wire        chip_select_low,
  input  wire        write_strobe_low,
  // speed strap pin and wake event source
  input  wire        speed_sel,
  input  wire        wake_event,
  // wake request pin, two-signal form: level and active-low enable
  output reg         wake_request_out,
  output reg         wake_request_oe_n,
  // default link settings
  output reg         speed100,
  output reg         full_duplex,
  output reg         autoneg_en
);
  // combined reset: pin (pulled up, so open reads high) or power-on
  // either source alone clears everything; the pin never needs a driver
  wire rst_n;
  assign rst_n = presetn & por_n;

  reg  [4:0] ctrl_q;
  reg        asleep_q;
  reg        event_q;
  reg        read_seen_q;
  reg        strap_q;
  reg        strap_taken_q;
  reg  [1:0] strap_cnt_q;
  wire       cs_s;
  wire       wr_s;
  wire       strap_s;
  reg        host_wr_q;
  wire       ctrl_wr;

  // synchronise the asynchronous pins
  rwsc_sync2 #(.RESET_VAL(1'b1)) u_cs (
    .pclk    (pclk),
    .presetn (rst_n),
    .din     (chip_select_low),
    .dout    (cs_s)
  );
  rwsc_sync2 #(.RESET_VAL(1'b1)) u_wr (
    .pclk    (pclk),
    .presetn (rst_n),
    .din     (write_strobe_low),
    .dout    (wr_s)
  );
  rwsc_sync2 #(.RESET_VAL(1'b1)) u_strap (
    .pclk    (pclk),
    .presetn (rst_n),
    .din     (speed_sel),
    .dout    (strap_s)
  );

  // mapped word offsets; feeds the error answer and the read-seen flag
  function rwsc_hit;
    input [11:0] a;
    begin
      rwsc_hit = (a == `RWSC_OFF_CTRL) | (a == `RWSC_OFF_STATUS) |
                 (a == `RWSC_OFF_BYTE_TEST);
    end
  endfunction

  // apb decode; a transfer acts only at the edge that shows pready high,
  // so an access phase held over two edges is never counted twice
  wire acc  = psel & penable;
  wire wr_a = acc & pwrite & pready;
  wire rd_a = acc & ~pwrite & pready;
  wire hit  = rwsc_hit(paddr);

  // an awake, read-qualified write to the control word
  // read opens writes
  assign ctrl_wr = wr_a & read_seen_q & ~asleep_q &
                   (paddr == `RWSC_OFF_CTRL);

  // registered host write qualifier: both strobes low together
  // the syncs reset high like the idle pins, so release shows no write
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      host_wr_q <= 1'b0;
    end else begin
      host_wr_q <= ~cs_s & ~wr_s;
    end
  end

  // strap taken once the sync shows the pin rather than its reset value;
  // the pin must stay put for the first few edges after release
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q   <= 2'h0;
      strap_q       <= 1'b0;
      strap_taken_q <= 1'b0;
    end else if (strap_cnt_q != `RWSC_STRAP_SETTLE) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else if (!strap_taken_q) begin
      strap_q       <= strap_s;
      strap_taken_q <= 1'b1;
    end
  end

  // default link settings from the latched strap
  // half duplex in both cases; only speed and autoneg follow the strap
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      speed100    <= 1'b0;
      full_duplex <= 1'b0;
      autoneg_en  <= 1'b0;
    end else begin
      speed100    <= strap_q;
      full_duplex <= 1'b0;
      autoneg_en  <= strap_q;
    end
  end

  // control register; sleep bit cleared by wake, writes need prior read
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= `RWSC_CTRL_RESET;
      asleep_q    <= 1'b0;
      read_seen_q <= 1'b0;
    end else begin
      if (rd_a && hit)
        read_seen_q <= 1'b1;
      if (asleep_q) begin
        if (host_wr_q || wr_a) begin
          asleep_q                 <= 1'b0;
          ctrl_q[`RWSC_CTRL_SLEEP] <= 1'b0;
          read_seen_q              <= 1'b0; // a read is needed again
        end
      end else if (ctrl_wr) begin
        // the clear bit is a strobe and is never stored
        ctrl_q   <= {1'b0, pwdata[3:0]};
        asleep_q <= pwdata[`RWSC_CTRL_SLEEP];
      end
    end
  end

  // sticky wake event; a new event wins over a clear in the same cycle
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      event_q <= 1'b0;
    end else if (wake_event && ctrl_q[`RWSC_CTRL_WAKE_EN]) begin
      event_q <= 1'b1;
    end else if (ctrl_wr && pwdata[`RWSC_CTRL_EVT_CLR]) begin
      event_q <= 1'b0;
    end
  end

  // wake request pin; open drain only ever pulls to the active level
  // when released, the board pull sets the idle level, not this flop
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request_out  <= 1'b0;
      wake_request_oe_n <= 1'b1;
    end else begin
      wake_request_out <= event_q ~^ ctrl_q[`RWSC_CTRL_POL_HIGH];
      if (ctrl_q[`RWSC_CTRL_PUSH_PULL])
        wake_request_oe_n <= 1'b0;
      else
        wake_request_oe_n <= ~event_q;
    end
  end

  // apb answer: one wait state, registered outputs
  // pready falls after one cycle, so an access held on is answered again every second edge
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `RWSC_OFF_CTRL:      prdata <= {27'h0, ctrl_q};
          `RWSC_OFF_STATUS:    prdata <= {25'h0, read_seen_q, event_q,
                                          asleep_q, autoneg_en,
                                          full_duplex, speed100, strap_q};
          `RWSC_OFF_BYTE_TEST: prdata <= `RWSC_BYTE_TEST_VAL;
          default:             prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // rwsc_top

// ---- core/rwsc_consts.vh ----
`ifndef RWSC_CONSTS_VH
`define RWSC_CONSTS_VH
// register offsets (byte addresses)
`define RWSC_OFF_CTRL    12'h000
`define RWSC_OFF_STATUS  12'h004
`define RWSC_OFF_BYTE_TEST 12'h008
// control register fields
`define RWSC_CTRL_WAKE_EN    0
`define RWSC_CTRL_POL_HIGH   1
`define RWSC_CTRL_PUSH_PULL  2
`define RWSC_CTRL_SLEEP      3
`define RWSC_CTRL_EVT_CLR    4
// status register fields
`define RWSC_ST_STRAP        0
`define RWSC_ST_SPEED100     1
`define RWSC_ST_FULL_DUPLEX  2
`define RWSC_ST_AUTONEG      3
`define RWSC_ST_ASLEEP       4
`define RWSC_ST_EVENT        5
`define RWSC_ST_READ_SEEN    6
// reset values
`define RWSC_CTRL_RESET      5'h00
`define RWSC_BYTE_TEST_VAL   32'h87654321
// timing counts: edges after reset release before the strap sync holds the pin
`define RWSC_STRAP_SETTLE    2'h2
`endif

// ---- core/rwsc_sync2.v ----
`timescale 1ns/1ps
// two-flop synchroniser for a level from outside pclk
module rwsc_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // level in and out
  input  wire din,
  output reg  dout
);
  reg meta_q;

  // first flop feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // rwsc_sync2

// ---- tb/rwsc_chk.sv ----
`timescale 1ns/1ps
// apb answer and link-default checks on the top ports
module rwsc_chk (
  // clock and resets
  input wire        pclk,
  input wire        presetn,
  input wire        por_n,
  // apb request and answer
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // latched link defaults
  input wire        speed100,
  input wire        full_duplex,
  input wire        autoneg_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!(presetn && por_n));
  // one wait state, one-cycle answer
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late pready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_erl; pslverr |=> !pslverr; endproperty
  a_erl: assert property (p_erl) else $error("long pslverr");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray prdata");
  property p_dup; !full_duplex; endproperty
  a_dup: assert property (p_dup) else $error("full duplex");
  property p_neg; speed100 == autoneg_en; endproperty
  a_neg: assert property (p_neg) else $error("autoneg mismatch");
  property p_hold; speed100 |=> speed100; endproperty
  a_hold: assert property (p_hold) else $error("strap lost");
endmodule // rwsc_chk
bind rwsc_top rwsc_chk rwsc_chk_inst (
  .pclk(pclk),
  .presetn(presetn),
  .por_n(por_n),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .prdata(prdata),
  .speed100(speed100),
  .full_duplex(full_duplex),
  .autoneg_en(autoneg_en)
);

// ---- tb/rwsc_host.sv ----
`timescale 1ns/1ps
// host pin writer; pins idle high as with the pull-ups
module rwsc_host (
  input  wire pclk,
  input  wire go,
  output reg  chip_select_low = 1'b1,
  output reg  write_strobe_low = 1'b1
);
  integer n = 0;
  // qualified pin write, held long enough for the sync
  always @(posedge pclk) begin
    if (go) n <= 4;
    else if (n != 0) n <= n - 1;
    chip_select_low <= !(go || n > 1);
    write_strobe_low <= !(go || n > 1);
  end
endmodule // rwsc_host

// ---- tb/reset_wake_strap_control_tb_top.sv ----
`timescale 1ns/1ps
`include "rwsc_consts.vh"
// bench for the reset, wake and strap block
module reset_wake_strap_control_tb_top;
  reg pclk = 0, presetn = 0, por_n = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, rd, rnd;
  reg speed_sel = 0, wake_event = 0, go = 0, er;
  wire [31:0] prdata;
  wire pready, pslverr, chip_select_low, write_strobe_low, wake_request_out;
  wire wake_request_oe_n, speed100, full_duplex, autoneg_en;
  integer errors = 0, checks = 0, seed = 32'h5e46, cyc = 0;
  rwsc_top rwsc_top_inst (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_low(chip_select_low), .write_strobe_low(write_strobe_low),
    .speed_sel(speed_sel), .wake_event(wake_event),
    .wake_request_out(wake_request_out),
    .wake_request_oe_n(wake_request_oe_n), .speed100(speed100),
    .full_duplex(full_duplex), .autoneg_en(autoneg_en)
  );
  rwsc_host rwsc_host_inst (
    .pclk(pclk), .go(go), .chip_select_low(chip_select_low),
    .write_strobe_low(write_strobe_low)
  );
  initial forever #50 pclk = ~pclk;
  // timeout well past the expected run length
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      conclude;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // expected link outputs and low status bits for a strap level
  function [2:0] link(input s);
    link = {s, 1'b0, s};
  endfunction
  function [3:0] stat(input s);
    stat = {s, 1'b0, s, s};
  endfunction
  // one apb transfer, released only at the edge that sees pready;
  // only the bench timeout ends a wait that never answers
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // reset through the pin or the power-on source; the first strap is
  // random, the second flips it so both levels get latched
  task rst(input p);
    rnd = $random(seed);
    speed_sel <= p ? !speed_sel : rnd[0];
    presetn <= p;
    por_n <= !p;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    repeat (5) @(posedge pclk);
    check({speed100, full_duplex, autoneg_en}, link(speed_sel));
    check({wake_request_out, wake_request_oe_n}, 2'b11);
    apb(1, `RWSC_OFF_CTRL, 32'h7);
    apb(0, `RWSC_OFF_CTRL, 0);
    check(rd, 0);
    apb(0, `RWSC_OFF_STATUS, 0);
    check(rd[3:0], stat(speed_sel));
  endtask
  initial begin
    rst(0);
    // writes land once a read has been made
    apb(1, `RWSC_OFF_CTRL, 32'h7);
    apb(0, `RWSC_OFF_CTRL, 0);
    check(rd, 7);
    // push-pull, active high
    wake_event <= 1;
    repeat (3) @(posedge pclk);
    check({wake_request_out, wake_request_oe_n}, 2'b10);
    // open drain with the event cleared: pin released
    wake_event <= 0;
    apb(1, `RWSC_OFF_CTRL, 32'h13);
    apb(0, `RWSC_OFF_STATUS, 0);
    check({rd[5], wake_request_oe_n}, 2'b01);
    apb(0, `RWSC_OFF_CTRL, 0);
    check(rd, 32'h3);
    // push-pull, active low
    apb(1, `RWSC_OFF_CTRL, 32'h5);
    wake_event <= 1;
    repeat (3) @(posedge pclk);
    check({wake_request_out, wake_request_oe_n}, 2'b00);
    // asleep: the request pin does not wake the device
    apb(1, `RWSC_OFF_CTRL, 32'h0b);
    repeat (3) @(posedge pclk);
    apb(0, `RWSC_OFF_STATUS, 0);
    check({rd[4], wake_request_oe_n}, 2'b10);
    // host pin write wakes the device
    wake_event <= 0;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (10) @(posedge pclk);
    apb(0, `RWSC_OFF_STATUS, 0);
    check(rd[4], 0);
    // sleep again, then wake by a write carrying random data
    apb(1, `RWSC_OFF_CTRL, 32'h08);
    apb(0, `RWSC_OFF_STATUS, 0);
    check(rd[4], 1);
    rnd = $random(seed);
    // wake write aimed at the byte-order word
    apb(1, `RWSC_OFF_BYTE_TEST, rnd);
    apb(0, `RWSC_OFF_BYTE_TEST, 0);
    check(rd, `RWSC_BYTE_TEST_VAL);
    apb(0, `RWSC_OFF_STATUS, 0);
    check(rd[4], 0);
    apb(0, 12'h0ff, 0);
    check({er, rd[0]}, 2'b10);
    // wake enable off: an event leaves no mark
    apb(1, `RWSC_OFF_CTRL, 32'h10);
    wake_event <= 1;
    repeat (3) @(posedge pclk);
    wake_event <= 0;
    apb(0, `RWSC_OFF_STATUS, 0);
    check(rd[5], 0);
    // control set before the power-on reset, so clearing it shows
    apb(1, `RWSC_OFF_CTRL, 32'h7);
    rst(1);
    conclude;
  end
endmodule // reset_wake_strap_control_tb_top
